// ### src/special_register_write_guard.sv
// Write guard for the special registers on the peripheral register bus.
// Assumes one write or read per cycle at most, synchronous to CLK_I.
`timescale 1ns/100ps
module special_register_write_guard import wr_guard_pkg::*; (
  input wire logic CLK_I, // Peripheral bus clock
  input wire logic RSTN_I, // Async reset, active low
  input wire logic [ADDR_W-1:0] ADDR_I, // Byte address
  input wire logic WR_I, // Write strobe, one cycle per store
  input wire logic RD_I, // Plain read strobe
  input wire logic [7:0] WDATA_I, // Write data (already merged for bit ops)
  output logic [7:0] RDATA_O, // Read data, registered
  output logic PROT_WE_O, // Protected write accepted, pulse
  output logic [2:0] PROT_SEL_O, // Index of protected register written
  output logic [7:0] PROT_WDATA_O, // Data for protected register
  output logic ARMED_O, // Unlock armed
  output logic IRQ_BLOCK_O, // Interrupt acknowledge held off
  output logic PROT_ERR_O // Protection error flag
);

  // Guard states: locked until an unlock store arms the next write
  typedef enum logic {
    GUARD_LOCKED,
    GUARD_ARMED
  } guard_e;

  // Guard index that no protected register uses
  localparam logic [2:0] NO_PROT = 3'd7;

  // Guard index of an address, NO_PROT when the address is unguarded
  function automatic logic [2:0] prot_index(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = NO_PROT;
    unique case (addr)
      PWR_SAVE_ADDR: idx = 3'd0;
      CPU_CLK_ADDR: idx = 3'd1;
      CLK_MON_ADDR: idx = 3'd2;
      RST_SRC_ADDR: idx = 3'd3;
      LOW_VOLT_ADDR: idx = 3'd4;
      RAM_STAT_ADDR: idx = 3'd5;
      DBG_MODE_ADDR: idx = 3'd6;
      default: idx = NO_PROT;
    endcase
    return idx;
  endfunction

  // True when the bus address equals one register address
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    return (addr == target);
  endfunction

  // Guard state
  guard_e state_q;
  guard_e state_d;

  // Protection error flag
  logic err_q;
  logic err_d;

  // Accepted protected write: pulse, index and data
  logic we_q;
  logic we_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [7:0] wd_q;
  logic [7:0] wd_d;

  // Read data register
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  // Address decode results
  wire logic [2:0] prot_idx;
  wire logic hit_prot;
  wire logic hit_unlock;
  wire logic hit_sys;

  // Qualified bus events
  wire logic armed;
  wire logic wr_unlock;
  wire logic wr_prot;
  wire logic wr_bad;
  wire logic wr_clear;

  // Decode of the seven guarded addresses and the two plain ones
  assign prot_idx = prot_index(ADDR_I);
  assign hit_prot = (prot_idx != NO_PROT);
  assign hit_unlock = addr_is(ADDR_I, UNLOCK_ADDR);
  assign hit_sys = addr_is(ADDR_I, SYS_STATUS_ADDR);

  // Current guard state as a flag
  assign armed = (state_q == GUARD_ARMED);

  // Any value stored to the unlock register arms; data is ignored
  assign wr_unlock = WR_I && hit_unlock;

  // Byte store or merged bit op is the same write here; only when armed
  assign wr_prot = WR_I && hit_prot && armed;

  // Protected write unarmed, or armed write anywhere else, unlock included
  assign wr_bad = WR_I && ((hit_prot && !armed) || (armed && !hit_prot));

  // Zero stored to the error bit of the status register
  assign wr_clear = WR_I && hit_sys && !WDATA_I[ERR_BIT];

  // Guard state: reads leave it alone, any write ends the armed window
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      GUARD_LOCKED: begin
        if (wr_unlock) begin
          state_d = GUARD_ARMED;
        end
      end
      GUARD_ARMED: begin
        if (WR_I) begin
          state_d = GUARD_LOCKED;
        end
      end
    endcase
  end

  // Error flag: a clearing write takes precedence over a violation in the same store
  always_comb begin
    err_d = err_q;
    if (wr_clear) begin
      err_d = 1'b0;
    end else if (wr_bad) begin
      err_d = 1'b1;
    end
  end

  // Protected write handed on: pulse for one cycle, index and data held after it
  always_comb begin
    we_d = wr_prot;
    sel_d = sel_q;
    wd_d = wd_q;
    if (wr_prot) begin
      sel_d = prot_idx;
      wd_d = WDATA_I;
    end
  end

  // Read data: status flag, undefined unlock value, zero elsewhere
  always_comb begin
    rd_d = rd_q;
    if (RD_I) begin
      rd_d = RST_BYTE;
      if (hit_sys) begin
        rd_d[ERR_BIT] = err_q;
      end else if (hit_unlock) begin
        rd_d = UNDEF_READ;
      end
    end
  end

  // Guard state register; reads never move it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= GUARD_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  // Error flag register, cleared by reset
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      err_q <= RST_FLAG;
    end else begin
      err_q <= err_d;
    end
  end

  // Write pulse register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      we_q <= RST_FLAG;
    end else begin
      we_q <= we_d;
    end
  end

  // Index and data of the last accepted protected write
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_q <= RST_SEL;
      wd_q <= RST_BYTE;
    end else begin
      sel_q <= sel_d;
      wd_q <= wd_d;
    end
  end

  // Read data register, updated only by a read
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_q <= RST_BYTE;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Outputs straight from the registers
  assign RDATA_O = rd_q;
  assign PROT_WE_O = we_q;
  assign PROT_SEL_O = sel_q;
  assign PROT_WDATA_O = wd_q;
  assign ARMED_O = armed;

  // Interrupts held off while armed so the protected store follows at once
  assign IRQ_BLOCK_O = armed;

  // Error flag as seen in the status register
  assign PROT_ERR_O = err_q;

  // Notes for users of this block:
  // The guarded registers themselves live elsewhere; this block only hands
  // on the index and data of an accepted store with a one-cycle pulse.
  // Bit operations reach this block as merged byte stores, so a set, clear
  // or invert after unlocking behaves exactly like a plain byte store.
  // A read between unlock and protected store keeps the window open, but
  // a store of any kind closes it, whether or not the store is accepted.
  // A second unlock store while armed counts as a stray write: it flags an
  // error and disarms, so software must start the sequence again.
  // Clearing the error with a zero store right after an unlock wins over the
  // stray-write error that the same store would otherwise raise.
  // Reads of the unlock register return a fixed value and never arm.
  // The read data register keeps its value until the next read.
  // All state returns to locked, no error, on reset.
endmodule

// ### src/wr_guard_pkg.sv
// Constants for the special-register write guard.
// Assumes an 8-bit peripheral register bus with byte address, write and read strobes.
package wr_guard_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 12'h_01FC;
  localparam logic [ADDR_W-1:0] SYS_STATUS_ADDR = 12'h_0802;
  localparam logic [ADDR_W-1:0] PWR_SAVE_ADDR = 12'h_01FE;
  localparam logic [ADDR_W-1:0] CPU_CLK_ADDR = 12'h_0828;
  localparam logic [ADDR_W-1:0] CLK_MON_ADDR = 12'h_0870;
  localparam logic [ADDR_W-1:0] RST_SRC_ADDR = 12'h_0888;
  localparam logic [ADDR_W-1:0] LOW_VOLT_ADDR = 12'h_0890;
  localparam logic [ADDR_W-1:0] RAM_STAT_ADDR = 12'h_0892;
  localparam logic [ADDR_W-1:0] DBG_MODE_ADDR = 12'h_09FC;
  localparam int ERR_BIT = 0;
  localparam int NUM_PROT = 7;
  localparam logic [7:0] UNDEF_READ = 8'h_00;
  localparam logic [7:0] RST_BYTE = 8'h_00;
  localparam logic [2:0] RST_SEL = 3'd0;
  localparam logic RST_FLAG = 1'b0;
endpackage

// ### dv/guard_monitor.sv
// Port assertions for the special-register write guard.
// Bound onto the guard top module by the bench.
`timescale 1ns/100ps
module guard_monitor import wr_guard_pkg::*; (
  input wire logic CLK_I, RSTN_I, WR_I, RD_I, PROT_WE_O, ARMED_O, IRQ_BLOCK_O, PROT_ERR_O, // Strobes, flags
  input wire logic [ADDR_W-1:0] ADDR_I, input wire logic [7:0] WDATA_I // Address, data
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Store to one address; unlock store while disarmed
  sequence s_wr(a); WR_I && ADDR_I == a; endsequence
  sequence s_arm; !ARMED_O ##0 s_wr(UNLOCK_ADDR); endsequence
  AST_ARM: assert property (s_arm |=> ARMED_O) else $error("no arm");
  AST_TAKE: assert property (s_arm ##1 s_wr(CPU_CLK_ADDR) |=> PROT_WE_O) else $error("no take");
  AST_MISS: assert property (s_arm ##1 s_wr(UNLOCK_ADDR) |=> PROT_ERR_O) else $error("no error");
  AST_BARE: assert property (!ARMED_O ##0 s_wr(PWR_SAVE_ADDR) |=> PROT_ERR_O && !PROT_WE_O) else $error("bare");
  AST_DIS: assert property (WR_I && ARMED_O |=> !ARMED_O) else $error("no disarm");
  AST_CLR: assert property (s_wr(SYS_STATUS_ADDR) ##0 !WDATA_I[0] |=> !PROT_ERR_O) else $error("no clear");
  AST_HOLD: assert property (RD_I && !WR_I |=> $stable(ARMED_O) && $stable(PROT_ERR_O)) else $error("read");
  AST_IRQ: assert property (s_arm |=> IRQ_BLOCK_O) else $error("irq hold");
endmodule

// ### dv/cpu_store_model.sv
// CPU core model issuing peripheral loads and stores.
// Assumes the guard samples the bus on the rising clock edge.
`timescale 1ns/100ps
module cpu_store_model import wr_guard_pkg::*; (
  input wire logic clk_i, // Clock
  output logic [ADDR_W-1:0] addr_o, output logic [1:0] op_o, output logic [7:0] data_o // Address, store/load, data
);
  initial {addr_o, op_o, data_o} = '0;
  // One access a cycle: drive op, address and data, then wait for the rising edge plus 1 ns
  task automatic acc(input logic [1:0] op, input logic [ADDR_W-1:0] ad, input logic [7:0] d);
    {addr_o, op_o, data_o} = {ad, op, d};
    @(posedge clk_i) #1;
  endtask
endmodule

// ### dv/tb.sv
// Bench for the special-register write guard.
// Assumes one-cycle answers; a CPU model drives the bus.
`timescale 1ns/100ps
module tb import wr_guard_pkg::*;;
  logic CLK_I = 0, RSTN_I = 0, WR_I, RD_I, PROT_WE_O, ARMED_O, IRQ_BLOCK_O, PROT_ERR_O;
  logic [1:0] op;
  logic [7:0] WDATA_I, RDATA_O, PROT_WDATA_O;
  logic [2:0] PROT_SEL_O;
  logic [ADDR_W-1:0] ADDR_I, prot [7] = '{PWR_SAVE_ADDR, CPU_CLK_ADDR, CLK_MON_ADDR, RST_SRC_ADDR, LOW_VOLT_ADDR,
    RAM_STAT_ADDR, DBG_MODE_ADDR};
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #12.5 CLK_I = !CLK_I;
  always @(posedge CLK_I) if (++cyc > 500) begin fail_count++; conclude(); end
  assign {WR_I, RD_I} = op; // Model op code: 2 store, 1 load, 0 idle
  cpu_store_model cpu (.clk_i(CLK_I), .addr_o(ADDR_I), .op_o(op), .data_o(WDATA_I));
  special_register_write_guard uut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .PROT_WE_O(PROT_WE_O), .PROT_SEL_O(PROT_SEL_O),
    .PROT_WDATA_O(PROT_WDATA_O), .ARMED_O(ARMED_O), .IRQ_BLOCK_O(IRQ_BLOCK_O), .PROT_ERR_O(PROT_ERR_O));
  task automatic chk(input string name, input logic [12:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin fail_count++; $display("wrong value %s expected %h seen %h", name, exp, seen); end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK_I);
    #1 RSTN_I = 1;
    for (int i = 0; i < NUM_PROT; i++) begin
      cpu.acc(2, UNLOCK_ADDR, 8'(i + 1)); chk("arm", {PROT_WE_O, ARMED_O, IRQ_BLOCK_O}, 3'b011);
      cpu.acc(2, prot[i], 8'(i + 1));
      chk("take", {PROT_WE_O, PROT_SEL_O, PROT_WDATA_O, ARMED_O}, {1'b1, 3'(i), 8'(i + 1), 1'b0});
      if (i == 0) begin repeat (5) cpu.acc(0, '0, '0); chk("pulse", PROT_WE_O, 0); end
    end
    cpu.acc(2, UNLOCK_ADDR, 0); cpu.acc(1, CPU_CLK_ADDR, 0); cpu.acc(1, UNLOCK_ADDR, 0);
    chk("undef read", {RDATA_O, ARMED_O, PROT_ERR_O}, {UNDEF_READ, 1'b1, 1'b0});
    cpu.acc(2, CPU_CLK_ADDR, 8'h_5A); chk("dummy", {PROT_WE_O, PROT_SEL_O, PROT_WDATA_O}, {1'b1, 3'd1, 8'h_5A});
    $display("test protected writes done");
    cpu.acc(2, PWR_SAVE_ADDR, 1); chk("bare", {PROT_WE_O, PROT_ERR_O}, 2'b01);
    cpu.acc(1, SYS_STATUS_ADDR, 0); chk("status", RDATA_O, 8'(1 << ERR_BIT));
    cpu.acc(2, UNLOCK_ADDR, 0); cpu.acc(2, SYS_STATUS_ADDR, 0); chk("clear", {ARMED_O, PROT_ERR_O}, 2'b00);
    cpu.acc(2, UNLOCK_ADDR, 0); cpu.acc(2, 12'h_0C00, 0); chk("stray", {ARMED_O, PROT_ERR_O, PROT_WE_O}, 3'b010);
    cpu.acc(2, SYS_STATUS_ADDR, 0); chk("plain clear", PROT_ERR_O, 0);
    cpu.acc(2, UNLOCK_ADDR, 0); cpu.acc(2, UNLOCK_ADDR, 0); chk("twice", {ARMED_O, PROT_ERR_O}, 2'b01);
    $display("test errors done");
    RSTN_I = 0; cpu.acc(0, '0, '0); chk("reset", {PROT_ERR_O, ARMED_O, PROT_WE_O}, 0);
    RSTN_I = 1; cpu.acc(2, UNLOCK_ADDR, 0); cpu.acc(2, LOW_VOLT_ADDR, 8'h_3C);
    chk("after reset", {PROT_WE_O, PROT_SEL_O, PROT_WDATA_O}, {1'b1, 3'd4, 8'h_3C});
    $display("test reset done");
    conclude();
  end
endmodule
bind special_register_write_guard guard_monitor mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I), .RD_I(RD_I),
  .PROT_WE_O(PROT_WE_O), .ARMED_O(ARMED_O), .IRQ_BLOCK_O(IRQ_BLOCK_O), .PROT_ERR_O(PROT_ERR_O),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I));
